// File: hw/hpid_pkg.sv
// package: register map, field layout, reset values and types for impedance detect
package hpid_pkg;
    // register word addresses (printed offsets are not all multiples of four: byte addr = 4*index)
    localparam logic [9:0] CAL_A_IDX   = 10'h087;
    localparam logic [9:0] CAL_B_IDX   = 10'h088;
    localparam logic [9:0] DRV_L_IDX   = 10'h225;
    localparam logic [9:0] CTRL_IDX    = 10'h29b; // trigger, range, hold, mode
    localparam logic [9:0] STAT_IDX    = 10'h29c; // complete flag, raw code
    localparam logic [9:0] LEVEL_IDX   = 10'h29d; // coarse level
    localparam logic [9:0] GPIO_IDX    = 10'h29e; // gpio source select
    // control and status register fields
    localparam int TRIG_BIT   = 0;
    localparam int RANGE_LSB  = 9;
    localparam int HOLD_LSB   = 5;
    localparam int MODE_LSB   = 12;
    localparam int DONE_BIT   = 15;
    // driver control fields
    localparam int FLWR_BIT   = 2;
    localparam int CLMPI_BIT  = 1;
    localparam int CLMPO_BIT  = 0;
    localparam int OUT_EN_BIT = 3;
    // reset values
    localparam logic [1:0] RANGE_RST = 2'h0;
    localparam logic [2:0] HOLD_RST  = 3'h1;
    localparam logic [2:0] MODE_RST  = 3'h0;
    localparam logic [3:0] DRV_RST   = 4'h6; // follower 1, input clamp 1, output clamp 0
    // factory calibration defaults, arbitrary neutral values
    localparam logic [15:0] CAL_A_RST = 16'h0000;
    localparam logic [15:0] CAL_B_RST = 16'h0000;
    // raw code validity window, for software
    localparam logic [9:0] RAW_MIN = 10'd169;
    localparam logic [9:0] RAW_MAX = 10'd1019;
    // detect clock: 50 MHz / 3125 = 16 kHz
    localparam int SYS_CLK_HZ = 50000000;
    localparam int DET_CLK_HZ = 16000;
    localparam int DET_DIV    = SYS_CLK_HZ / DET_CLK_HZ;
    // detect mode codes
    typedef enum logic [2:0] {
        HPID_MODE_OFF   = 3'h0,
        HPID_MODE_LEFT  = 3'h1,
        HPID_MODE_RIGHT = 3'h2,
        HPID_MODE_MIC   = 3'h4
    } hpid_mode_e;
    // result from the analogue sweep
    typedef struct packed {
        logic       valid;
        logic [9:0] raw;
        logic [7:0] level;
    } hpid_result_s;
    // analogue sweep request
    typedef struct packed {
        logic       start;
        logic [1:0] range;
        logic [2:0] pin_sel;
    } hpid_sweep_s;
endpackage

// File: hw/hpid_core.sv
// impedance detect control, results, calibration, driver bits, avalon slave
// Behaviour
// (R1) writing one to measure_trigger starts a new measurement every time
// (R2) complete flag sets at measurement end, stays until next trigger
// (R3) raw_result_code of the finished measurement is readable once complete
// (R4) software accepts raw codes only between 169 and 1019 inclusive
// (R5) software starts at range 00, increments range when code below 169
// (R6) coarse_level_field reported on completion, usable inside selected range
// (R7) on mic detect pin only level is valid, range setting ignored
// (R8) completion drives an event input of the interrupt controller
// (R9) detection status offered as a selectable general-purpose output source
// (R10) software decode keeps at least five decimal places
// (R11) offset and gradient calibration fields are factory-set, software readable
// (R12) base_offset_cal signed 6-bit at bits 9:4 of calibration a
// (R13) range deltas signed 4-bit; range3 delta split over bits 15:14
// (R14) slope fields signed 7-bit half steps at 13:7 and 6:0 of b
// (R15) software clears follower and input clamp, sets output clamp bit
// (R16) output enable change reloads follower, clamps; resets 1,1,0
// (R17) detect_mode_sel 001 left, 010 right, 100 mic pin
// (R18) impedance_range_sel 00..11 chooses range; only valid for left or right
// (R19) ramp_hold_time picks 1..1024 detect clocks between ramps, reset 001
// (R20) trigger reads zero; trigger write clears complete flag same cycle
//
// Our own choice: the Avalon-MM interface to the registers.
module hpid_core #(
    parameter int DET_DIV_P = hpid_pkg::DET_DIV
) (
    // clock and reset
    input  wire logic                  sys_clk_i,
    input  wire logic                  nrst_i,
    // avalon-mm slave
    input  wire logic [11:0]           avs_address_i,
    input  wire logic                  avs_read_i,
    input  wire logic                  avs_write_i,
    input  wire logic [31:0]           avs_writedata_i,
    input  wire logic [3:0]            avs_byteenable_i,
    output logic      [31:0]           avs_readdata_o,
    output logic                       avs_waitrequest_o,
    output logic      [1:0]            avs_response_o,
    // analogue sweep
    output hpid_pkg::hpid_sweep_s      sweep_o,
    output logic                       hold_tick_o,
    input  wire hpid_pkg::hpid_result_s result_i,
    // left driver enable from output path
    input  wire logic                  left_out_en_i,
    // events and indication
    output logic                       irq_event_o,
    output logic                       gpio_o
);
    import hpid_pkg::*;

    // registers
    logic [15:0] cal_a_r, cal_b_r;
    logic [2:0]  drv_r;
    logic [1:0]  range_r;
    logic [2:0]  hold_r;
    logic [2:0]  mode_r;
    logic        gpio_sel_r;
    logic        done_r;
    logic [9:0]  raw_r;
    logic [7:0]  level_r;
    logic        busy_r;
    logic [31:0] rdata_r;
    logic        ack_r;
    logic        resp_err_r;
    logic        start_r;
    logic        irq_r, gpio_r, tick_r;
    logic [11:0] div_r;
    logic [10:0] hold_cnt_r;
    logic        en_q1_r, en_q2_r, en_q3_r;

    // bus decode: one wait cycle on every access, answer on the second edge
    wire        req      = (avs_read_i | avs_write_i) & ~ack_r;
    wire [9:0]  idx      = avs_address_i[11:2];
    wire        wr       = avs_write_i & ~ack_r & avs_byteenable_i[0] & avs_byteenable_i[1];
    wire        hit_cal_a = idx == CAL_A_IDX;
    wire        hit_cal_b = idx == CAL_B_IDX;
    wire        hit_drv  = idx == DRV_L_IDX;
    wire        hit_ctrl = idx == CTRL_IDX;
    wire        hit_stat = idx == STAT_IDX;
    wire        hit_lvl  = idx == LEVEL_IDX;
    wire        hit_gpio = idx == GPIO_IDX;
    wire        mapped   = hit_cal_a | hit_cal_b | hit_drv | hit_ctrl | hit_stat | hit_lvl
                           | hit_gpio;
    wire        trig_wr  = wr & hit_ctrl & avs_writedata_i[TRIG_BIT]; // [R1]
    wire        mic_mode = mode_r == HPID_MODE_MIC;

    // calibration field views
    wire signed [5:0] base_offset_cal      = cal_a_r[9:4];                      // [R12]
    wire signed [3:0] range0_offset_delta  = cal_a_r[3:0];                      // [R13]
    wire signed [3:0] range2_offset_delta  = cal_a_r[13:10];                    // [R13]
    wire signed [3:0] range3_offset_delta  = {cal_b_r[15:14], cal_a_r[15:14]}; // [R13]
    wire signed [6:0] high_range_slope_cal = cal_b_r[13:7];                     // [R14]
    wire signed [6:0] low_range_slope_cal  = cal_b_r[6:0];                      // [R14]

    // read mux; trigger bit always reads zero
    wire [15:0] ctrl_rd = {1'b0, mode_r, 1'b0, range_r, 1'b0, hold_r, 5'h00}; // [R20]
    wire [15:0] stat_rd = {done_r, 5'h00, raw_r};                            // [R2] [R3]
    wire [15:0] rd_mux  =
        hit_cal_a ? {range3_offset_delta[1:0], range2_offset_delta,
                     base_offset_cal, range0_offset_delta} :                  // [R11]
        hit_cal_b ? {range3_offset_delta[3:2], high_range_slope_cal,
                     low_range_slope_cal} :                                   // [R11]
        hit_drv   ? {12'h000, left_out_en_i, drv_r} :
        hit_ctrl  ? ctrl_rd :
        hit_stat  ? stat_rd :
        hit_lvl   ? {8'h00, level_r} :                                        // [R6]
        hit_gpio  ? {15'h0000, gpio_sel_r} : 16'h0000;

    // left driver enable passes three flops; an agreed change is an edge
    wire        en_edge  = en_q2_r == en_q3_r ? 1'b0 : 1'b1;
    wire        en_now   = en_q2_r;

    // hold time in detect clocks
    wire [10:0] hold_len =
        hold_r == 3'h0 ? 11'd1   : hold_r == 3'h1 ? 11'd4   :
        hold_r == 3'h2 ? 11'd16  : hold_r == 3'h3 ? 11'd64  :
        hold_r == 3'h4 ? 11'd256 : hold_r == 3'h5 ? 11'd512 :
        hold_r == 3'h6 ? 11'd768 : 11'd1024;                                  // [R19]
    wire        det_tick = div_r == 12'(DET_DIV_P - 1);

    // bus handshake and read data
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ack_r      <= 1'b0;
            rdata_r    <= 32'h0000_0000;
            resp_err_r <= 1'b0;
        end else begin
            ack_r      <= req;
            rdata_r    <= req ? {16'h0000, rd_mux} : rdata_r;
            resp_err_r <= req & ~mapped;
        end
    end

    // calibration and configuration writes
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cal_a_r    <= CAL_A_RST;
            cal_b_r    <= CAL_B_RST;
            range_r    <= RANGE_RST;
            hold_r     <= HOLD_RST;
            mode_r     <= MODE_RST;
            gpio_sel_r <= 1'b0;
        end else if (wr) begin
            if (hit_cal_a) cal_a_r <= avs_writedata_i[15:0];
            if (hit_cal_b) cal_b_r <= avs_writedata_i[15:0];
            if (hit_gpio) gpio_sel_r <= avs_writedata_i[0];
            if (hit_ctrl) begin
                range_r <= avs_writedata_i[RANGE_LSB +: 2];
                hold_r  <= avs_writedata_i[HOLD_LSB +: 3];
                mode_r  <= avs_writedata_i[MODE_LSB +: 3];
            end
        end
    end

    // left driver bits: software writes; enable rise loads 001, enable fall reloads defaults
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            drv_r <= DRV_RST[2:0];
            en_q1_r <= 1'b0;
            en_q2_r <= 1'b0;
            en_q3_r <= 1'b0;
        end else begin
            en_q1_r <= left_out_en_i;
            en_q2_r <= en_q1_r;
            en_q3_r <= en_q2_r;
            if (en_edge)
                drv_r <= en_now ? 3'b001 : DRV_RST[2:0];                      // [R16]
            else if (wr & hit_drv)
                drv_r <= avs_writedata_i[2:0];                                // [R15]
        end
    end

    // measurement sequencing, completion and results
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            start_r <= 1'b0;
            busy_r  <= 1'b0;
            done_r  <= 1'b0;
            raw_r   <= 10'h000;
            level_r <= 8'h00;
            irq_r   <= 1'b0;
        end else begin
            start_r <= trig_wr;                                               // [R1]
            irq_r   <= 1'b0;
            if (trig_wr) begin
                busy_r <= 1'b1;
                done_r <= 1'b0;                                               // [R20]
            end else if (busy_r & result_i.valid & ~start_r) begin
                busy_r  <= 1'b0;
                done_r  <= 1'b1;                                              // [R2]
                raw_r   <= mic_mode ? 10'h000 : result_i.raw;                 // [R3] [R7]
                level_r <= result_i.level;                                    // [R6]
                irq_r   <= 1'b1;                                              // [R8]
            end
        end
    end

    // detect clock divider and hold counter
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            div_r      <= 12'h000;
            hold_cnt_r <= 11'h000;
            tick_r     <= 1'b0;
        end else begin
            div_r  <= det_tick ? 12'h000 : div_r + 12'h001;
            tick_r <= 1'b0;
            if (start_r)
                hold_cnt_r <= hold_len;
            else if (det_tick && hold_cnt_r != 11'h000) begin
                hold_cnt_r <= hold_cnt_r - 11'h001;
                tick_r     <= hold_cnt_r == 11'h001;                          // [R19]
            end
        end
    end

    // gpio indication: complete flag or measurement in progress
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i)
            gpio_r <= 1'b0;
        else
            gpio_r <= gpio_sel_r ? busy_r : done_r;                           // [R9]
    end

    // sweep request, range ignored in mic mode
    logic [5:0] sweep_r;
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i)
            sweep_r <= 6'h00;
        else
            sweep_r <= {start_r, mic_mode ? 2'b00 : range_r, mode_r};        // [R7] [R17] [R18]
    end

    assign sweep_o           = sweep_r;
    assign hold_tick_o       = tick_r;
    assign irq_event_o       = irq_r;
    assign gpio_o            = gpio_r;
    assign avs_readdata_o    = rdata_r;
    assign avs_waitrequest_o = ~ack_r;
    assign avs_response_o    = {resp_err_r, 1'b0};
endmodule

// File: bench/hpid_properties.sv
// checker: bus handshake, trigger, completion and readback relations of hpid_core
module hpid_props #(
    parameter int DET_DIV_P = 4
) (
    input wire logic                   sys_clk_i,
    input wire logic                   nrst_i,
    input wire logic [11:0]            avs_address_i,
    input wire logic                   avs_read_i,
    input wire logic                   avs_write_i,
    input wire logic [31:0]            avs_writedata_i,
    input wire logic [3:0]             avs_byteenable_i,
    input wire logic [31:0]            avs_readdata_o,
    input wire logic                   avs_waitrequest_o,
    input wire logic [1:0]             avs_response_o,
    input wire hpid_pkg::hpid_sweep_s  sweep_o,
    input wire hpid_pkg::hpid_result_s result_i,
    input wire logic                   irq_event_o
);
    import hpid_pkg::*;
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!nrst_i);
    // request decode
    wire logic [9:0] idx    = avs_address_i[11:2];
    wire logic       mapped = idx inside {CAL_A_IDX, CAL_B_IDX, DRV_L_IDX, CTRL_IDX,
                                          STAT_IDX, LEVEL_IDX, GPIO_IDX};
    wire logic       rd_ack = avs_read_i && !avs_waitrequest_o;
    wire logic       trig   = avs_write_i && avs_waitrequest_o && idx == CTRL_IDX
                              && avs_byteenable_i[1:0] == 2'h3 && avs_writedata_i[TRIG_BIT];
    chk_ack_follows: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
        |=> !avs_waitrequest_o) else $error("request not answered next cycle");
    chk_ack_one: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
        else $error("waitrequest low longer than one cycle");
    chk_trig_start: assert property (trig |-> ##[1:2] sweep_o.start)
        else $error("trigger write gave no sweep start");
    chk_start_pulse: assert property (sweep_o.start |=> !sweep_o.start)
        else $error("sweep start longer than one cycle");
    chk_mic_range: assert property (sweep_o.start && sweep_o.pin_sel == HPID_MODE_MIC
        |-> sweep_o.range == 2'h0) else $error("range not ignored on mic pin");
    chk_irq_cause: assert property (irq_event_o
        |-> $past(result_i.valid) || $past(result_i.valid, 2)) else $error("irq without result");
    chk_irq_pulse: assert property (irq_event_o |=> !irq_event_o)
        else $error("irq event longer than one cycle");
    chk_trig_zero: assert property (rd_ack && idx == CTRL_IDX
        |-> !avs_readdata_o[TRIG_BIT]) else $error("trigger bit read as one");
    chk_resp_code: assert property (!avs_waitrequest_o && (avs_read_i || avs_write_i)
        |-> avs_response_o == (mapped ? 2'h0 : 2'h2)) else $error("wrong response code");
    chk_upper_zero: assert property (rd_ack |-> avs_readdata_o[31:16] == 16'h0)
        else $error("upper read data not zero");
    // main scenarios
    cov_start: cover property (sweep_o.start);
    cov_irq: cover property (irq_event_o);
    cov_err: cover property (!avs_waitrequest_o && avs_response_o == 2'h2);
endmodule

bind hpid_core hpid_props #(.DET_DIV_P(DET_DIV_P)) u_hpid_props (
    .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .avs_response_o(avs_response_o),
    .sweep_o(sweep_o), .result_i(result_i), .irq_event_o(irq_event_o));

// File: bench/hpid_sweep_model.sv
// sweep model: analogue load answering each sweep start with a result after a delay
module hpid_sweep_model (
    input  wire logic                   sys_clk_i,
    input  wire logic                   nrst_i,
    input  wire hpid_pkg::hpid_sweep_s  sweep_i,
    output hpid_pkg::hpid_result_s      result_o
);
    timeunit 1ns;
    timeprecision 1ps;
    int         wait_n;
    logic [1:0] rng;
    // higher ranges answer slower; range 00 lands below the valid window
    always @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            wait_n = 0;
            result_o <= '0;
        end else begin
            result_o.valid <= 1'b0;
            result_o.raw <= ~result_o.raw; // released lines do not hold
            if (sweep_i.start) begin
                wait_n = 6 + 8 * sweep_i.range;
                rng = sweep_i.range;
            end else if (wait_n > 0) begin
                wait_n = wait_n - 1;
                if (wait_n == 0) begin
                    result_o.valid <= 1'b1;
                    result_o.raw <= (rng == 2'h0) ? 10'd100 : 10'd300 + 10'd200 * rng;
                    result_o.level <= 8'h10 + {6'h0, rng};
                end
            end
        end
    end
endmodule

// File: bench/headphone_impedance_detect_test.sv
// testbench: register access, measurement sequence, modes and driver reload
module headphone_impedance_detect_test
    import hpid_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic         sys_clk_i = 1'b0;
    logic         nrst_i = 1'b0;
    logic [11:0]  avs_address_i = 12'h0;
    logic         avs_read_i = 1'b0;
    logic         avs_write_i = 1'b0;
    logic [31:0]  avs_writedata_i = 32'h0;
    logic [3:0]   avs_byteenable_i = 4'hf;
    logic         left_out_en_i = 1'b0;
    logic [31:0]  avs_readdata_o;
    logic         avs_waitrequest_o, irq_event_o, gpio_o, hold_tick_o;
    logic [1:0]   avs_response_o, rs;
    logic [15:0]  rd;
    logic [2:0]   last_pin;
    hpid_sweep_s  sweep_o;
    hpid_result_s result_i;
    int           n_fail = 0, samples_checked = 0, n_irq = 0, n_tick = 0;
    always #10 sys_clk_i = ~sys_clk_i;
    // record irq pulses and the pin of each sweep start
    always @(posedge sys_clk_i) begin
        if (irq_event_o === 1'b1) n_irq <= n_irq + 1;
        if (hold_tick_o === 1'b1) n_tick <= n_tick + 1;
        if (sweep_o.start === 1'b1) last_pin <= sweep_o.pin_sel;
    end
    hpid_core #(.DET_DIV_P(4)) u_hpid_core (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i),
        .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
        .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
        .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
        .avs_response_o(avs_response_o), .sweep_o(sweep_o), .hold_tick_o(hold_tick_o),
        .result_i(result_i), .left_out_en_i(left_out_en_i), .irq_event_o(irq_event_o),
        .gpio_o(gpio_o));
    hpid_sweep_model u_hpid_sweep_model (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i),
        .sweep_i(sweep_o), .result_o(result_i));
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic check(input string name, input logic [31:0] seen, exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // one avalon transfer, held until waitrequest is sampled low
    task automatic bus(input logic we, input logic [9:0] idx, input logic [15:0] wd,
                       input logic [3:0] be = 4'hf);
        int n;
        n = 0;
        @(posedge sys_clk_i);
        avs_address_i <= {idx, 2'b00};
        avs_writedata_i <= {16'h0, wd};
        avs_byteenable_i <= be;
        avs_write_i <= we;
        avs_read_i <= ~we;
        do begin
            @(posedge sys_clk_i);
            n++;
        end while (avs_waitrequest_o !== 1'b0 && n < 20);
        rd = avs_readdata_o[15:0];
        rs = avs_response_o;
        avs_read_i <= 1'b0;
        avs_write_i <= 1'b0;
        if (n >= 20) begin
            n_fail++;
            test_done();
        end
    endtask
    task automatic rd_chk(input logic [9:0] idx, input logic [15:0] exp, input string name);
        bus(1'b0, idx, 16'h0);
        check(name, {rs, rd}, {2'h0, exp});
    endtask
    // trigger one measurement, see the flag drop, poll until complete
    task automatic measure(input logic [2:0] mode, input logic [1:0] rng);
        int n;
        int t0;
        n = 0;
        t0 = n_tick;
        bus(1'b1, CTRL_IDX, {1'b0, mode, 1'b0, rng, 1'b0, 3'h1, 4'h0, 1'b1});
        bus(1'b0, STAT_IDX, 16'h0);
        check("done_clear", rd[15], 1'b0);
        do begin
            bus(1'b0, STAT_IDX, 16'h0);
            n++;
        end while (rd[15] !== 1'b1 && n < 60);
        check("done_set", rd[15], 1'b1);
        check("pin", last_pin, mode);
        check("gpio", gpio_o, 1'b1);
        n = 0;
        while (n_tick == t0 && n < 60) begin
            @(posedge sys_clk_i);
            n++;
        end
        check("hold_tick", n_tick - t0, 1);
    endtask
    task automatic t_cal();
        bus(1'b1, CAL_A_IDX, 16'hc5a3);
        rd_chk(CAL_A_IDX, 16'hc5a3, "cal_a");
        bus(1'b1, CAL_B_IDX, 16'h8e41);
        rd_chk(CAL_B_IDX, 16'h8e41, "cal_b");
        bus(1'b1, CAL_A_IDX, 16'h1234, 4'h1);
        rd_chk(CAL_A_IDX, 16'hc5a3, "cal_part");
        bus(1'b0, 10'h3ff, 16'h0);
        check("unmapped", {rs, rd}, {2'h2, 16'h0});
    endtask
    task automatic t_search();
        logic [1:0] r;
        r = 2'h0;
        measure(HPID_MODE_LEFT, r);
        while (rd[9:0] < RAW_MIN && r != 2'h3) begin
            r++;
            measure(HPID_MODE_LEFT, r);
        end
        check("range", r, 2'h1);
        check("raw", rd[9:0], 10'd500);
        rd_chk(LEVEL_IDX, 16'h0011, "level");
        check("irqs", n_irq, 2);
        measure(HPID_MODE_RIGHT, 2'h2);
        check("raw_r", rd[9:0], 10'd700);
        measure(HPID_MODE_MIC, 2'h3);
        check("raw_mic", rd[9:0], 10'h0);
        rd_chk(LEVEL_IDX, 16'h0010, "lvl_mic");
    endtask
    task automatic t_driver();
        bus(1'b1, DRV_L_IDX, 16'h0001);
        rd_chk(DRV_L_IDX, 16'h0001, "drv_det");
        bus(1'b1, DRV_L_IDX, 16'h0006);
        left_out_en_i <= 1'b1;
        repeat (6) @(posedge sys_clk_i);
        rd_chk(DRV_L_IDX, 16'h0009, "drv_on");
        left_out_en_i <= 1'b0;
        repeat (6) @(posedge sys_clk_i);
        rd_chk(DRV_L_IDX, 16'h0006, "drv_off");
    endtask
    // main sequence
    initial begin
        repeat (20) @(posedge sys_clk_i);
        nrst_i <= 1'b1;
        rd_chk(CTRL_IDX, 16'h0020, "ctrl_rst");
        rd_chk(DRV_L_IDX, 16'h0006, "drv_rst");
        rd_chk(CAL_B_IDX, CAL_B_RST, "cal_rst");
        t_cal();
        t_search();
        t_driver();
        test_done();
    end
endmodule
